// file: pkg/usx_regs.svh
/*
 register offsets, field positions, reset values and timing counts of the
 serial mode and transmit control block. assumes a 32-bit ahb-lite slave.
*/
`ifndef USX_REGS_SVH
`define USX_REGS_SVH
`define USX_OFF_TSC 8'h98
`define USX_OFF_RSC 8'h18
`define USX_OFF_TXD 8'h19
`define USX_OFF_BAUD 8'h9C
`define USX_OFF_DIR 8'h86
`define USX_TSC_CLKSRC 7
`define USX_TSC_NINE 6
`define USX_TSC_TXON 5
`define USX_TSC_SYNC 4
`define USX_TSC_HISPD 2
`define USX_TSC_EMPTY 1
`define USX_TSC_BIT9 0
`define USX_RSC_SERIAL_PORT_ENABLE 7
`define USX_RSC_SINGLE_RECEIVE_ENABLE 5
`define USX_RSC_CONTINUOUS_RECEIVE_ENABLE 4
`define USX_TSC_RESET 8'h02
`define USX_RSC_RESET 8'h00
`define USX_DIR_RESET 8'hFF
`define USX_BAUD_RESET 8'h00
`define USX_SYNC_DIV 4
`define USX_ASYNC_DIV_HI 16
`define USX_ASYNC_DIV_LO 64
`endif

// file: pkg/usx_pkg.sv
/*
 types of the serial mode and transmit control block.
 assumes usx_regs.svh holds the numeric constants.
*/
package usx_pkg;
  typedef enum logic [1:0] {USX_ASYNC, USX_SYNC_MASTER, USX_SYNC_SLAVE} usx_mode_e;
  typedef enum {USX_IDLE, USX_SHIFT, USX_STOP} usx_tx_state_e;
endpackage

// file: hdl/usx_mem.sv
/*
 small word memory with registered read data.
 assumes one write and one read port on the same clock.
*/
module usx_mem #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [WIDTH-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read address
  output logic [WIDTH-1:0] rdata // registered read data
);
  logic [WIDTH-1:0] mem [DEPTH];
  // =====================
  // storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: hdl/usx_fifo.sv
/*
 valid/ready fifo with honest full and empty, on top of usx_mem.
 assumes a single clock; read data have one cycle of latency hidden by a
 show-ahead output register.
*/
module usx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // word out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("usx_fifo depth must be a power of two");
    end
  end
  logic [AW:0] wptr, rptr;
  logic [AW-1:0] raddr;
  logic pend, out_v;
  logic [WIDTH-1:0] mdata, hold;
  // words held: memory, word in flight to the output register, output register
  wire [AW+1:0] used = {1'b0, wptr - rptr} + (AW+2)'(pend) + (AW+2)'(out_v);
  wire empty = (wptr == rptr);
  wire push = in_valid && in_ready;
  wire slot_free = !out_v || out_ready;
  wire pop = !empty && !pend && slot_free;
  assign in_ready = (used < (AW+2)'(DEPTH)); // never more than depth words in all
  assign raddr = rptr[AW-1:0];
  assign out_valid = out_v;
  assign out_data = hold;
  usx_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk(clk), .we(push), .waddr(wptr[AW-1:0]), .wdata(in_data),
    .raddr(raddr), .rdata(mdata)
  );
  // =====================
  // pointers and show-ahead register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr <= '0;
      rptr <= '0;
      pend <= 1'b0;
      out_v <= 1'b0;
      hold <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      pend <= pop;
      if (pend) begin
        hold <= mdata;
        out_v <= 1'b1;
      end else if (out_ready) begin
        out_v <= 1'b0;
      end
    end
  end
endmodule

// file: hdl/usx_ctrl.sv
/*
 serial mode and transmit control: mode/control registers on ahb-lite,
 pin enabling, baud generation, a transmit shifter fed through a fifo.
 assumes a single master, word transfers, and pins sampled from outside.
*/
`include "usx_regs.svh"
// Summary of operation
// RULE1 - modes: asynchronous full duplex, synchronous master or slave, half duplex
// RULE2 - pins serve the port only with port enable and both direction bits set
// RULE3 - in sync mode clock source set means master, clear means external clock
// RULE4 - nine-bit select picks 9-bit characters, else 8-bit
// RULE5 - transmitter on bit enables the transmitter
// RULE6 - mode select bit set chooses synchronous, clear asynchronous
// RULE7 - in async mode speed select picks high or low baud rate
// RULE8 - shift-register-empty reads 1 when empty, 0 when holding data, resets 1
// RULE9 - bit 0 is sent as the ninth data bit in 9-bit mode
// RULE10 - in sync mode either receive enable overrides transmit enable
// RULE11 - sync bit rate is clock over four times divisor plus one
// RULE12 - sync slave shifts only on edges of the externally supplied clock
module usx_ctrl #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk, // 40 mhz system clock
  input wire logic arst_n, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write transfer
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic tx_clock_pin_in, // clock pin level
  output logic tx_clock_pin_out, // clock pin drive value
  output logic tx_clock_pin_oe, // clock pin driven
  input wire logic rx_data_pin_in, // data pin level
  output logic rx_data_pin_out, // data pin drive value
  output logic rx_data_pin_oe // data pin driven
);
  initial begin
    if (FIFO_DEPTH < 2) $error("usx_ctrl fifo too small");
  end
  // =====================
  // register bus
  logic [7:0] tsc, rsc, baud_divisor, portb_direction;
  logic shift_reg_empty;
  logic ap_wr, ap_rd;
  logic [7:0] ap_addr;
  wire ap_take = hsel && hready && htrans[1];
  wire sel_tsc = (ap_addr == `USX_OFF_TSC);
  wire sel_rsc = (ap_addr == `USX_OFF_RSC);
  wire sel_txd = (ap_addr == `USX_OFF_TXD);
  wire sel_baud = (ap_addr == `USX_OFF_BAUD);
  wire sel_dir = (ap_addr == `USX_OFF_DIR);
  wire [7:0] tsc_view = {tsc[7:4], 1'b0, tsc[2], shift_reg_empty, tsc[0]}; // RULE8
  wire [7:0] rd_mux = sel_tsc ? tsc_view : sel_rsc ? rsc : sel_baud ? baud_divisor :
    sel_dir ? portb_direction : 8'h00;
  logic fifo_in_ready;
  wire txd_wr = ap_wr && sel_txd;
  // stall a data write while the fifo is full
  assign hreadyout = !(txd_wr && !fifo_in_ready);
  assign hresp = 1'b0;
  // address phase capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hreadyout) begin
      ap_wr <= ap_take && hwrite;
      ap_rd <= ap_take && !hwrite;
      ap_addr <= haddr[7:0];
    end
  end
  // read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite) hrdata <= {24'h00_0000, next_rd(haddr[7:0])};
  end
  function automatic logic [7:0] next_rd(input logic [7:0] a);
    next_rd = (a == `USX_OFF_TSC) ? tsc_view : (a == `USX_OFF_RSC) ? rsc :
      (a == `USX_OFF_BAUD) ? baud_divisor : (a == `USX_OFF_DIR) ? portb_direction : 8'h00;
  endfunction
  // control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tsc <= `USX_TSC_RESET;
      rsc <= `USX_RSC_RESET;
      baud_divisor <= `USX_BAUD_RESET;
      portb_direction <= `USX_DIR_RESET;
    end else if (ap_wr && hreadyout) begin
      if (sel_tsc) tsc <= hwdata[7:0] & 8'hF5;
      if (sel_rsc) rsc <= hwdata[7:0];
      if (sel_baud) baud_divisor <= hwdata[7:0];
      if (sel_dir) portb_direction <= hwdata[7:0];
    end
  end
  // =====================
  // mode decode
  wire serial_port_enable = rsc[`USX_RSC_SERIAL_PORT_ENABLE];
  wire port_on = serial_port_enable && portb_direction[2] && portb_direction[1]; // RULE2
  wire sync_mode = tsc[`USX_TSC_SYNC]; // RULE6
  wire clock_source_select = tsc[`USX_TSC_CLKSRC];
  wire rx_override = rsc[`USX_RSC_SINGLE_RECEIVE_ENABLE] || rsc[`USX_RSC_CONTINUOUS_RECEIVE_ENABLE];
  usx_pkg::usx_mode_e mode;
  assign mode = !sync_mode ? usx_pkg::USX_ASYNC : clock_source_select ? // RULE1
    usx_pkg::USX_SYNC_MASTER : usx_pkg::USX_SYNC_SLAVE; // RULE3
  wire transmitter_on = tsc[`USX_TSC_TXON] && !(sync_mode && rx_override); // RULE5 RULE10
  wire nine_bit_tx_select = tsc[`USX_TSC_NINE];
  wire high_speed_baud_select = tsc[`USX_TSC_HISPD];
  // =====================
  // pin synchronisers and baud generator
  logic [1:0] ck_sync, dt_sync;
  logic ck_last;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_sync <= 2'b00;
      dt_sync <= 2'b00;
      ck_last <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[0], tx_clock_pin_in};
      dt_sync <= {dt_sync[0], rx_data_pin_in};
      ck_last <= ck_sync[1];
    end
  end
  wire ext_fall = ck_last && !ck_sync[1]; // RULE12
  // sync: rate clk/(4(n+1)); async: 16(n+1) or 64(n+1) cycles per bit
  wire [15:0] div_sync = 16'(`USX_SYNC_DIV) * ({8'h00, baud_divisor} + 16'h0001); // RULE11
  wire [15:0] div_async = (high_speed_baud_select ? 16'(`USX_ASYNC_DIV_HI) :
    16'(`USX_ASYNC_DIV_LO)) * ({8'h00, baud_divisor} + 16'h0001); // RULE7
  wire [15:0] half_period = sync_mode ? {1'b0, div_sync[15:1]} : div_async;
  logic [15:0] bcnt;
  logic bclk;
  wire btick = (bcnt >= half_period - 16'h0001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt <= 16'h0000;
      bclk <= 1'b1;
    end else if (btick) begin
      bcnt <= 16'h0000;
      bclk <= !bclk;
    end else begin
      bcnt <= bcnt + 16'h0001;
    end
  end
  wire int_fall = btick && bclk;
  // one shift step per bit time in each mode
  wire step = (mode == usx_pkg::USX_SYNC_SLAVE) ? ext_fall :
    (mode == usx_pkg::USX_SYNC_MASTER) ? int_fall : btick;
  // =====================
  // transmit fifo and shifter
  logic fifo_out_valid, fifo_pop;
  logic [8:0] fifo_out_data;
  usx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .arst_n(arst_n),
    .in_valid(txd_wr), .in_ready(fifo_in_ready),
    .in_data({tsc[`USX_TSC_BIT9], hwdata[7:0]}), // RULE9
    .out_valid(fifo_out_valid), .out_ready(fifo_pop), .out_data(fifo_out_data)
  );
  usx_pkg::usx_tx_state_e st;
  logic [10:0] transmit_shift_reg;
  logic [3:0] bits_left;
  logic tx_line;
  assign fifo_pop = (st == usx_pkg::USX_IDLE) && transmitter_on && port_on && fifo_out_valid;
  wire [3:0] frame_bits = nine_bit_tx_select ? 4'd9 : 4'd8; // RULE4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= usx_pkg::USX_IDLE;
      transmit_shift_reg <= 11'h7FF;
      bits_left <= 4'h0;
      tx_line <= 1'b1;
      shift_reg_empty <= 1'b1;
    end else begin
      case (st)
        usx_pkg::USX_IDLE: begin
          if (fifo_pop) begin
            // in 8-bit frames the slot after the data is the stop bit
            transmit_shift_reg <= {1'b1, nine_bit_tx_select ? fifo_out_data[8] : 1'b1, fifo_out_data[7:0], 1'b0};
            bits_left <= sync_mode ? frame_bits : frame_bits + 4'd2;
            if (sync_mode) transmit_shift_reg <= {2'b11, fifo_out_data}; // no start bit in sync
            shift_reg_empty <= 1'b0; // RULE8
            st <= usx_pkg::USX_SHIFT;
          end
        end
        usx_pkg::USX_SHIFT: begin
          if (step) begin
            tx_line <= transmit_shift_reg[0];
            transmit_shift_reg <= {1'b1, transmit_shift_reg[10:1]};
            bits_left <= bits_left - 4'd1;
            if (bits_left == 4'd1) st <= usx_pkg::USX_STOP;
          end
        end
        usx_pkg::USX_STOP: begin
          if (step) begin
            tx_line <= 1'b1;
            shift_reg_empty <= 1'b1;
            st <= usx_pkg::USX_IDLE;
          end
        end
        default: st <= usx_pkg::USX_IDLE;
      endcase
    end
  end
  // =====================
  // pin drive
  wire busy = (st != usx_pkg::USX_IDLE);
  assign tx_clock_pin_out = sync_mode ? bclk : tx_line;
  assign tx_clock_pin_oe = port_on && (sync_mode ? (mode == usx_pkg::USX_SYNC_MASTER) :
    tsc[`USX_TSC_TXON]); // RULE2 RULE3
  assign rx_data_pin_out = tx_line;
  assign rx_data_pin_oe = port_on && sync_mode && transmitter_on && busy; // RULE10
  wire unused_ok = ap_rd ^ dt_sync[1] ^ (|hsize) ^ (|rd_mux) ^ (|haddr[31:8]);
endmodule

// file: tb/usx_ctrl_props.sv
/*
 port-level checker of usx_ctrl, bound below.
 assumes hready is fed from hreadyout and one clock domain.
*/
// ==========
// checker
module usx_ctrl_props (
  input wire logic clk, // clock
  input wire logic arst_n, // reset, low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic [31:0] hrdata, // read data
  input wire logic tx_clock_pin_in, // clock pin level
  input wire logic tx_clock_pin_out, // clock pin drive
  input wire logic tx_clock_pin_oe, // clock pin driven
  input wire logic rx_data_pin_out, // data pin drive
  input wire logic rx_data_pin_oe // data pin driven
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // read requests taken and decode of the map
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire mapped = haddr == 32'h98 || haddr == 32'h18 || haddr == 32'h19 || haddr == 32'h9C || haddr == 32'h86;
  wire msync = tx_clock_pin_oe && rx_data_pin_oe;
  // slave transmit with the supplied clock held high
  sequence s_hi;
    (tx_clock_pin_in && rx_data_pin_oe && !tx_clock_pin_oe) [*3];
  endsequence
  sequence s_unmapped;
    rd_take && !mapped;
  endsequence
  property p_rst_idle; !$past(arst_n) |-> !tx_clock_pin_oe && !rx_data_pin_oe; endproperty
  property p_clk_hi; msync && $rose(tx_clock_pin_out) |=> tx_clock_pin_out; endproperty
  property p_clk_lo; msync && $fell(tx_clock_pin_out) |=> !tx_clock_pin_out; endproperty
  property p_slave_hold; s_hi |-> $stable(rx_data_pin_out); endproperty
  property p_tsc_rsvd; rd_take && haddr == 32'h98 |=> hrdata[3] == 1'b0; endproperty
  property p_unmapped; s_unmapped |=> hrdata == 32'h0; endproperty
  property p_rd_nowait; rd_take |=> hreadyout; endproperty
  property p_rd_hold; !rd_take |=> $stable(hrdata); endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins driven after reset");
  a_clk_hi: assert property (p_clk_hi) else $error("shift clock high too short");
  a_clk_lo: assert property (p_clk_lo) else $error("shift clock low too short");
  a_slave_hold: assert property (p_slave_hold) else $error("slave data moved");
  a_tsc_rsvd: assert property (p_tsc_rsvd) else $error("reserved bit set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_nowait: assert property (p_rd_nowait) else $error("read waited");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind usx_ctrl usx_ctrl_props u_props (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .tx_clock_pin_in, .tx_clock_pin_out, .tx_clock_pin_oe, .rx_data_pin_out, .rx_data_pin_oe);

// file: tb/usx_link_model.sv
/*
 far-side serial party: supplies the shift clock in slave mode.
 assumes both lines have pull-ups when nobody drives them.
*/
// ==========
// link model
module usx_link_model (
  input wire logic clk_oe, // device drives clock
  input wire logic clk_out, // device clock value
  input wire logic dat_oe, // device drives data
  input wire logic dat_out, // device data value
  output logic clk_in, // clock line level
  output logic dat_in // data line level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic drv = 1'b0;
  logic [7:0] cap = 8'h00;
  // line levels: device first, then model clock, else pull-up
  assign clk_in = clk_oe ? clk_out : (drv ? mclk : 1'b1);
  assign dat_in = dat_oe ? dat_out : 1'b1;
  // sample data on rising clock, first bit lowest
  always @(posedge mclk) cap <= {dat_in, cap[7:1]};
  // clock stands low between bursts, 200 ns period
  task pulse(input int k);
    #7;
    repeat (k) begin
      #100 mclk = 1'b1;
      #100 mclk = 1'b0;
    end
  endtask
endmodule

// file: tb/usx_ctrl_tb.sv
/*
 self-checking bench of usx_ctrl with a link model.
 assumes the design answers reads with no wait.
*/
// ==========
// bench
module usx_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire hreadyout, hresp, tco, tce, rdo, rde, tci, rdi;
  wire [31:0] hrdata;
  int error_cnt = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  usx_ctrl dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_clock_pin_in(tci), .tx_clock_pin_out(tco), .tx_clock_pin_oe(tce), .rx_data_pin_in(rdi),
    .rx_data_pin_out(rdo), .rx_data_pin_oe(rde));
  usx_link_model m (.clk_oe(tce), .clk_out(tco), .dat_oe(rde), .dat_out(rdo), .clk_in(tci), .dat_in(rdi));
  // ==========
  // helpers
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // one ahb-lite single transfer, held until hready
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    @(posedge clk);
    q = hrdata[7:0];
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
    // the write lands at the closing edge: let it settle before anyone looks
    @(negedge clk);
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task idle();
    logic [7:0] q;
    do xfer(1'b0, 8'h98, 8'h00, q); while (q[1] !== 1'b1);
  endtask
  // cycles until the line reaches a level
  task lvl(input logic v, output int n);
    n = 0;
    while (tco !== v) begin
      n++;
      @(negedge clk);
    end
  endtask
  // ==========
  // scenarios
  task t_regs();
    rc(8'h98, 8'h02);
    rc(8'h86, 8'hFF);
    rc(8'h9C, 8'h00);
    rc(8'h40, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    wr(8'h98, 8'hFF);
    rc(8'h98, 8'hF7);
    wr(8'h98, 8'h00);
    rc(8'h98, 8'h02);
  endtask
  task t_pins();
    wr(8'h18, 8'h80);
    wr(8'h98, 8'h20);
    chk({7'h0, tce}, 8'h01);
    wr(8'h86, 8'hFB);
    chk({7'h0, tce}, 8'h00);
    wr(8'h86, 8'hFD);
    chk({7'h0, tce}, 8'h00);
    wr(8'h86, 8'hFF);
    wr(8'h18, 8'h00);
    chk({7'h0, tce}, 8'h00);
    wr(8'h18, 8'h80);
  endtask
  task t_async();
    logic [10:0] exp;
    int n;
    exp = 11'b1_0_10100101_0;
    wr(8'h9C, 8'h01);
    wr(8'h98, 8'h64);
    wr(8'h19, 8'hA5);
    lvl(1'b0, n);
    fork
      rc(8'h98, 8'h64);
      for (int i = 0; i < 11; i++) begin
        cyc(i ? 32 : 16);
        chk({7'h0, tco}, {7'h0, exp[i]});
      end
    join
    idle();
    wr(8'h98, 8'h20);
    wr(8'h19, 8'h80);
    lvl(1'b0, n);
    lvl(1'b1, n);
    chk({7'h0, n == 1024}, 8'h01);
    idle();
  endtask
  task t_master();
    int a;
    int b;
    wr(8'h9C, 8'h02);
    wr(8'h98, 8'hB0);
    wr(8'h19, 8'h5A);
    cyc(4);
    chk({6'h0, tce, rde}, 8'h03);
    lvl(1'b0, a);
    lvl(1'b1, a);
    lvl(1'b0, a);
    lvl(1'b1, b);
    chk({7'h0, a + b == 12}, 8'h01);
    idle();
    for (int i = 0; i < 2; i++) begin
      wr(8'h18, i ? 8'h90 : 8'hA0);
      wr(8'h19, 8'hC3);
      cyc(40);
      chk({7'h0, rde}, 8'h00);
      wr(8'h18, 8'h80);
      idle();
    end
  endtask
  task t_slave();
    m.drv = 1'b1;
    wr(8'h98, 8'h30);
    chk({7'h0, tce}, 8'h00);
    wr(8'h19, 8'h3C);
    cyc(30);
    rc(8'h98, 8'h30);
    // first bit leaves on the first falling edge: a frame takes one clock more than its bits
    m.pulse(9);
    cyc(10);
    chk(m.cap, 8'h3C);
    idle();
  endtask
  task t_fifo();
    for (int i = 0; i < 33; i++) wr(8'h19, 8'(i));
    fork
      wr(8'h19, 8'h77);
      begin
        cyc(20);
        chk({7'h0, hreadyout}, 8'h00);
        m.pulse(9);
      end
    join
    // 33 words left, nine clocks each
    m.pulse(297);
    cyc(10);
    chk(m.cap, 8'h77);
    idle();
  endtask
  // reset in mid-run with the pins in use
  task t_reset();
    wr(8'h98, 8'h20);
    chk({7'h0, tce}, 8'h01);
    @(posedge clk);
    arst_n <= 1'b0;
    cyc(2);
    chk({6'h0, tce, rde}, 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    rc(8'h98, 8'h02);
    rc(8'h18, 8'h00);
  endtask
  // ==========
  // run and verdict
  task complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_pins();
    t_async();
    t_master();
    t_slave();
    t_fifo();
    t_reset();
    complete_run();
  end
  // cuts a hang short
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
endmodule
